// [ucs_pkg.sv]
// Package of the serial port control and status bank.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package ucs_pkg;
  // ----------------------------------------
  // Register byte offsets.
  // ----------------------------------------
  localparam logic [7:0] OFS_CORE_INT  = 8'h00; // Core interrupt control.
  localparam logic [7:0] OFS_PER_EN    = 8'h04; // Peripheral interrupt enables.
  localparam logic [7:0] OFS_PER_FLAG  = 8'h08; // Peripheral interrupt flags.
  localparam logic [7:0] OFS_RX_DATA   = 8'h0c; // Receive data.
  localparam logic [7:0] OFS_RX_CTL    = 8'h10; // Receive control and status.
  localparam logic [7:0] OFS_BAUD      = 8'h14; // Baud rate divisor.
  localparam logic [7:0] OFS_PORT_DIR  = 8'h18; // Port pin direction.
  localparam logic [7:0] OFS_TX_CTL    = 8'h1c; // Transmit control and status.
  // ----------------------------------------
  // Field positions.
  // ----------------------------------------
  localparam int B_CLK_SRC   = 7; // Clock source select.
  localparam int B_TX_WIDTH  = 6; // Transmit width select.
  localparam int B_TX_EN     = 5; // Transmitter enable bit.
  localparam int B_SYNC_MODE = 4; // Link mode select.
  localparam int B_HIGH_BAUD = 2; // High baud select.
  localparam int B_SHIFT_EMP = 1; // Shift empty flag.
  localparam int B_TX_NINTH  = 0; // Transmit ninth data bit.
  localparam int B_RX_NINTH  = 0; // Received ninth data bit.
  localparam int B_RX_PEND   = 5; // Receive pending flag / enable.
  localparam int B_TX_PEND   = 4; // Transmit pending flag / enable.
  localparam int B_GLOBAL_IE = 7; // Global interrupt enable.
  localparam int B_PERIPH_IE = 6; // Peripheral interrupt gate.
  // ----------------------------------------
  // Masks and reset values.
  // ----------------------------------------
  localparam logic [7:0] TX_WR_MASK   = 8'hf5; // Writable transmit bits.
  localparam logic [7:0] TX_RESET     = 8'h02; // Transmit reset pattern.
  localparam logic [7:0] RX_CTL_RESET = 8'h00; // Receive control reset.
  localparam logic [7:0] RX_CTL_WMASK = 8'hf8; // Writable receive control bits.
  localparam logic [7:0] CORE_WMASK   = 8'hc0; // Implemented core bits.
  localparam logic [7:0] PEN_WMASK    = 8'h30; // Implemented enable bits.
  localparam logic [7:0] ZERO8        = 8'h00; // All-zero byte.
  localparam logic [7:0] DIR_RESET    = 8'hff; // All pins input.
  localparam logic [4:0] SHIFT_BITS8  = 5'h0a; // Frame bits for 8-bit chars.
  localparam logic [4:0] SHIFT_BITS9  = 5'h0b; // Frame bits for 9-bit chars.
  // Transmit shifter state.
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} ucs_tx_e;
  // Masked write helper used for the transmit, receive control and interrupt registers.
  function automatic logic [7:0] ucs_merge(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] mask);
    ucs_merge = (old_v & ~mask) | (new_v & mask);
  endfunction : ucs_merge
endpackage : ucs_pkg

// [ucs_evt_if.sv]
// Interface carrying character events between the bank and its helpers.
// Assumes all parties share SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
interface ucs_evt_if;
  logic       load;   // Pulse: start shifting a character.
  logic       nine;   // Character width is nine bits.
  logic       tick;   // Bit-rate enable pulse.
  logic       busy;   // Shifter holds a character.
  logic [7:0] div;    // Baud divisor.
  logic       hs;     // High-speed scaling.
  logic       sync;   // Synchronous mode.
  modport bank  (output load, nine, div, hs, sync, input tick, busy);
  modport shift (input load, nine, tick, output busy);
  modport baud  (input div, hs, sync, output tick);
endinterface : ucs_evt_if
`default_nettype wire

// [ucs_baud.sv]
// Bit-rate enable divider for the serial port.
// Assumes the divisor and scaling select from the register bank.
`timescale 1ns/1ps
`default_nettype none
module ucs_baud
  import ucs_pkg::*;
(
  input  wire logic clk,    // System clock.
  input  wire logic rst_b,  // Asynchronous active-low reset.
  ucs_evt_if.baud   ev      // Divisor in, tick out.
);
  logic [9:0] cnt_q;  // Down counter.
  logic       tick_q; // Registered tick.
  // ----------------------------------------
  // Divider.
  // ----------------------------------------
  // Low speed or synchronous mode scales the divisor by four, asynchronous high speed by one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q  <= (ev.hs && !ev.sync) ? {2'b00, ev.div} : {ev.div, 2'b11};
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q - 10'd1;
      tick_q <= 1'b0;
    end
  end
  assign ev.tick = tick_q;
endmodule : ucs_baud
`default_nettype wire

// [ucs_shift.sv]
// Transmit shift register occupancy tracker.
// Assumes loads arrive only while idle.
`timescale 1ns/1ps
`default_nettype none
module ucs_shift
  import ucs_pkg::*;
(
  input  wire logic clk,    // System clock.
  input  wire logic rst_b,  // Asynchronous active-low reset.
  ucs_evt_if.shift  ev      // Load in, busy out.
);
  ucs_tx_e    st_q;  // Shifter state.
  logic [4:0] bits_q; // Bits left.
  // ----------------------------------------
  // Shifter.
  // ----------------------------------------
  // Counts frame bits out at the bit rate.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= TX_IDLE;
      bits_q <= '0;
    end else begin
      case (st_q)
        TX_IDLE: begin
          if (ev.load) begin
            st_q   <= TX_SHIFT;
            bits_q <= ev.nine ? SHIFT_BITS9 : SHIFT_BITS8;
          end
        end
        TX_SHIFT: begin
          if (ev.tick) begin
            if (bits_q == 5'h01) st_q <= TX_IDLE;
            bits_q <= bits_q - 5'h01;
          end
        end
        default: st_q <= TX_IDLE;
      endcase
    end
  end
  assign ev.busy = (st_q == TX_SHIFT);
endmodule : ucs_shift
`default_nettype wire

// [ucs_bank.sv]
// Control and status register bank of the serial port.
// Assumes an APB master on SYS_CLK; the receiver supplies characters.
//
// Behaviour
// - clock source bit selects master or slave in synchronous mode
// - width bit selects nine or eight bits
// - unimplemented bits read zero, ignore writes
// - transmit control resets to shift-empty only
// - receive control bits 7..1 clear on reset
// - eight-bit divisor register, clears on reset
// - receive flag bit5, transmit flag bit4
// - receive enable bit5, transmit enable bit4
// - global enable bit7, peripheral gate bit6
// - port direction resets to all ones
// - receive interrupt needs all three enables
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ucs_bank
  import ucs_pkg::*;
(
  input  wire logic        SYS_CLK,     // System clock, 50 MHz.
  input  wire logic        RST_B,       // Asynchronous reset, active low.
  input  wire logic        PSEL,        // APB select.
  input  wire logic        PENABLE,     // APB access phase.
  input  wire logic        PWRITE,      // APB direction.
  input  wire logic [7:0]  PADDR,       // APB byte address.
  input  wire logic [31:0] PWDATA,      // APB write data.
  output logic      [31:0] PRDATA,      // APB read data.
  output logic             PREADY,      // APB ready.
  output logic             PSLVERR,     // APB error on unmapped address.
  input  wire logic        RX_VALID,    // Pulse: received character.
  input  wire logic [8:0]  RX_CHAR,     // Received character with ninth bit.
  output logic             SHIFT_CLK_MASTER, // High: port makes the shift clock.
  output logic             BIT_TICK,    // Bit-rate enable pulse.
  output logic [7:0]       PIN_DIR,     // Port direction, one is input.
  output logic             IRQ          // Level interrupt request.
);
  ucs_evt_if ev ();                     // Link to helpers.
  logic [7:0] tx_q;                     // Transmit control and status.
  logic [7:0] rxc_q;                    // Receive control and status.
  logic [7:0] rxd_q;                    // Receive data.
  logic [7:0] baud_q;                   // Baud rate divisor.
  logic [7:0] dir_q;                    // Port pin direction.
  logic [7:0] core_q;                   // Core interrupt control.
  logic [7:0] pen_q;                    // Peripheral interrupt enables.
  logic       rx_pend_q;                // Receive pending flag.
  logic       tx_pend_q;                // Transmit pending flag.
  logic       load_q;                   // Shifter load pulse.
  logic       wr_acc;                   // Write access phase.
  logic       rd_acc;                   // Read access phase.
  logic       mapped;                   // Address hits a register.
  logic [7:0] rd_byte;                  // Read mux.
  logic       irq_d;                    // Next interrupt level.
  // ----------------------------------------
  // Bus decode.
  // ----------------------------------------
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_acc = PSEL && PENABLE && !PWRITE;
  // Address decode, also used for the error answer.
  always_comb begin
    mapped = 1'b1;
    case (PADDR)
      OFS_CORE_INT:  rd_byte = core_q;
      OFS_PER_EN:    rd_byte = pen_q;
      OFS_PER_FLAG:  rd_byte = 8'h00 | ({7'h00, rx_pend_q} << B_RX_PEND)
                                     | ({7'h00, tx_pend_q} << B_TX_PEND);
      OFS_RX_DATA:   rd_byte = rxd_q;
      OFS_RX_CTL:    rd_byte = rxc_q;
      OFS_BAUD:      rd_byte = baud_q;
      OFS_PORT_DIR:  rd_byte = dir_q;
      OFS_TX_CTL:    rd_byte = {tx_q[7:2], !ev.busy, tx_q[0]};
      default: begin
        rd_byte = ZERO8;
        mapped  = 1'b0;
      end
    endcase
  end
  // ----------------------------------------
  // APB answer, zero wait states.
  // ----------------------------------------
  // Read data is registered in the setup cycle so PRDATA is a flop.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? {24'h000000, rd_byte} : '0;
    end
  end
  // ----------------------------------------
  // Transmit control register.
  // ----------------------------------------
  // Bit 3 and the shift-empty bit are never stored from writes.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_q <= TX_RESET;
    end else if (wr_acc && PREADY && PADDR == OFS_TX_CTL) begin
      tx_q <= ucs_merge(tx_q, PWDATA[7:0], TX_WR_MASK);
    end
  end
  // ----------------------------------------
  // Read-write registers, some with masked writes, and the received ninth bit.
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      baud_q <= ZERO8;
      dir_q  <= DIR_RESET;
      core_q <= ZERO8;
      pen_q  <= ZERO8;
      rxc_q  <= RX_CTL_RESET;
    end else begin
      if (wr_acc && PREADY) begin
        case (PADDR)
          OFS_BAUD:     baud_q <= PWDATA[7:0];
          OFS_PORT_DIR: dir_q  <= PWDATA[7:0];
          OFS_CORE_INT: core_q <= ucs_merge(core_q, PWDATA[7:0], CORE_WMASK);
          OFS_PER_EN:   pen_q  <= ucs_merge(pen_q, PWDATA[7:0], PEN_WMASK);
          OFS_RX_CTL:   rxc_q  <= ucs_merge(rxc_q, PWDATA[7:0], RX_CTL_WMASK);
          default: begin
          end
        endcase
      end
      // The ninth bit is stored even when a bus write lands in the same cycle.
      if (RX_VALID) begin
        rxc_q[B_RX_NINTH] <= RX_CHAR[8];
      end
    end
  end
  // ----------------------------------------
  // Receive data and flags.
  // ----------------------------------------
  // Receive flag sets on a character, clears when data is read; set wins.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rxd_q     <= ZERO8;
      rx_pend_q <= 1'b0;
    end else begin
      if (RX_VALID) rxd_q <= RX_CHAR[7:0];
      if (RX_VALID) rx_pend_q <= 1'b1;
      else if (rd_acc && PREADY && PADDR == OFS_RX_DATA) rx_pend_q <= 1'b0;
    end
  end
  // Transmit flag is high while the transmitter is enabled and idle.
  // Writing the receive data word while the transmitter is enabled and idle starts a character.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_pend_q <= 1'b0;
      load_q    <= 1'b0;
    end else begin
      tx_pend_q <= tx_q[B_TX_EN] && !ev.busy && !load_q;
      load_q    <= wr_acc && PREADY && PADDR == OFS_RX_DATA && tx_q[B_TX_EN]
                   && !ev.busy;
    end
  end
  // ----------------------------------------
  // Helpers and outputs.
  // ----------------------------------------
  assign ev.load = load_q;
  assign ev.nine = tx_q[B_TX_WIDTH];
  assign ev.div  = baud_q;
  assign ev.hs   = tx_q[B_HIGH_BAUD];
  assign ev.sync = tx_q[B_SYNC_MODE];
  ucs_baud  u_baud  (.clk(SYS_CLK), .rst_b(RST_B), .ev(ev));
  ucs_shift u_shift (.clk(SYS_CLK), .rst_b(RST_B), .ev(ev));
  // Interrupt combines flag, enable, peripheral gate and global enable.
  always_comb begin
    irq_d = core_q[B_GLOBAL_IE] && core_q[B_PERIPH_IE] &&
            ((rx_pend_q && pen_q[B_RX_PEND]) || (tx_pend_q && pen_q[B_TX_PEND]));
  end
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ              <= 1'b0;
      SHIFT_CLK_MASTER <= 1'b0;
      BIT_TICK         <= 1'b0;
      PIN_DIR          <= DIR_RESET;
    end else begin
      IRQ              <= irq_d;
      SHIFT_CLK_MASTER <= tx_q[B_SYNC_MODE] && tx_q[B_CLK_SRC];
      BIT_TICK         <= ev.tick;
      PIN_DIR          <= dir_q;
    end
  end
  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  property p_irq_gate;
    @(posedge SYS_CLK) disable iff (!RST_B)
    IRQ |-> $past(core_q[B_GLOBAL_IE]) && $past(core_q[B_PERIPH_IE]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
  property p_tx_bit3;
    @(posedge SYS_CLK) disable iff (!RST_B) tx_q[3] == 1'b0;
  endproperty
  a_tx_bit3: assert property (p_tx_bit3) else $error("tx bit3 set");
  property p_rx_set;
    @(posedge SYS_CLK) disable iff (!RST_B) RX_VALID |=> rx_pend_q && rxd_q == $past(RX_CHAR[7:0]);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx flag not set");
  property p_master;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (tx_q[B_SYNC_MODE] && tx_q[B_CLK_SRC]) |=> SHIFT_CLK_MASTER;
  endproperty
  a_master: assert property (p_master) else $error("master clock not set");
  property p_empty;
    @(posedge SYS_CLK) disable iff (!RST_B) load_q |=> ev.busy;
  endproperty
  a_empty: assert property (p_empty) else $error("shifter not busy after load");
  property p_baud_wr;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (wr_acc && PREADY && PADDR == OFS_BAUD) |=> baud_q == $past(PWDATA[7:0]);
  endproperty
  a_baud_wr: assert property (p_baud_wr) else $error("divisor not written");
  property p_dir_out;
    @(posedge SYS_CLK) disable iff (!RST_B) ##1 PIN_DIR == $past(dir_q);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("direction mismatch");
  property p_pen_mask;
    @(posedge SYS_CLK) disable iff (!RST_B) (pen_q & ~PEN_WMASK) == ZERO8;
  endproperty
  a_pen_mask: assert property (p_pen_mask) else $error("enable reserved set");
endmodule : ucs_bank
`default_nettype wire

// [ucs_remote.sv]
// Remote serial transmitter model: hands finished characters to the bank.
// Assumes the bank samples the arrival pulse on the rising SYS_CLK edge.
`timescale 1ns/1ps
`default_nettype none
module ucs_remote (
  input  wire logic       clk,      // System clock.
  output logic            rx_valid, // One-cycle arrival pulse.
  output logic      [8:0] rx_char   // Character, bit 8 is the ninth bit.
);
  // Line starts idle.
  initial begin
    rx_valid = 1'b0;
    rx_char  = 9'h000;
  end
  // Delivers one character after some idle cycles, then shows its inverse,
  // so a stale value is never mistaken for a held one.
  task automatic send(input logic [8:0] c, input int gap);
    repeat (gap) @(posedge clk);
    rx_valid <= 1'b1;
    rx_char  <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char  <= ~c;
  endtask : send
endmodule : ucs_remote
`default_nettype wire

// [uart_control_status_bank_bench.sv]
// Self-checking bench of the serial port register bank.
// Assumes ucs_pkg, ucs_evt_if, ucs_baud, ucs_shift, ucs_bank and ucs_remote.
`timescale 1ns/1ps
`default_nettype none
module uart_control_status_bank_bench;
  import ucs_pkg::*;
  logic        sys_clk, rst_b, psel, penable, pwrite, last_err;
  logic [7:0]  paddr, pin_dir;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, rx_valid, clk_master, bit_tick, irq;
  logic [8:0]  rx_char;
  int          n_fail, num_checks, ticks;
  ucs_bank ucs_bank_i (.SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_CHAR(rx_char),
    .SHIFT_CLK_MASTER(clk_master), .BIT_TICK(bit_tick), .PIN_DIR(pin_dir), .IRQ(irq));
  ucs_remote ucs_remote_i (.clk(sys_clk), .rx_valid(rx_valid), .rx_char(rx_char));
  // 20 ns clock and idle bus at time zero.
  initial begin
    sys_clk = 1'b0;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Counts bit-rate pulses for the shift length checks.
  always @(posedge sys_clk) if (bit_tick === 1'b1) ticks++;
  // Prints counts and the verdict, then stops.
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request holds until PREADY is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rchk
  // Lets registered outputs settle, then samples between edges.
  task automatic look;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : look
  // Readback of a written byte.
  function automatic logic [7:0] rb(input logic [7:0] a, input logic [7:0] w);
    case (a)
      OFS_CORE_INT: rb = w & 8'hc0;
      OFS_PER_EN:   rb = w & 8'h30;
      OFS_RX_CTL:   rb = w & 8'hf8;
      OFS_TX_CTL:   rb = (w & 8'hf5) | 8'h02;
      default:      rb = w;
    endcase
  endfunction : rb
  // Resets, then every register must show its reset pattern.
  task automatic rst_check;
    logic [7:0] rv [8];
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h02};
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(8'(i * 4), {24'h0, rv[i]});
    chk({24'h0, pin_dir}, 32'hff);
  endtask : rst_check
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    logic [31:0] w;
    logic [8:0]  c;
    logic [7:0]  a, dw;
    logic [7:0]  md [3];
    logic [7:0]  st [4][3];
    int          d, p;
    md = '{8'h04, 8'h00, 8'h14};
    st = '{'{8'hc0, 8'h00, 8'h0}, '{8'hc0, 8'h20, 8'h1}, '{8'h80, 8'h20, 8'h0},
           '{8'h40, 8'h20, 8'h0}};
    void'($urandom(32'habc5));
    rst_check();
    // Read-only flags and an unmapped address.
    apb(1'b1, OFS_PER_FLAG, 32'hff);
    rchk(OFS_PER_FLAG, 32'h0);
    apb(1'b1, 8'h20, $urandom);
    chk({31'h0, last_err}, 32'h1);
    rchk(8'h20, 32'h0);
    // Random writes with reserved bits and upper bytes set.
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 8; i++) begin
        a = 8'(i * 4);
        w = $urandom;
        if (a == OFS_TX_CTL) w[B_SYNC_MODE] = 1'b0;
        if (a == OFS_PORT_DIR) dw = w[7:0];
        if (i != 2 && i != 3) begin
          apb(1'b1, a, w);
          rchk(a, {24'h0, rb(a, w[7:0])});
        end
      end
      chk({24'h0, pin_dir}, {24'h0, dw});
    end
    // Transmitter off first, so the zero write to the data word starts no character.
    apb(1'b1, OFS_TX_CTL, 32'h0);
    for (int i = 0; i < 8; i++) apb(1'b1, 8'(i * 4), 32'h0);
    // Clock source only makes the port master in synchronous mode.
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_TX_CTL, (k == 0) ? 32'h90 : (k == 1) ? 32'h80 : 32'h10);
      look();
      chk({31'h0, clk_master}, (k == 0) ? 32'h1 : 32'h0);
    end
    // Bit-rate period for each scaling mode.
    for (int k = 0; k < 3; k++) begin
      d = $urandom_range(7);
      apb(1'b1, OFS_BAUD, 32'(d));
      apb(1'b1, OFS_TX_CTL, {24'h0, md[k]});
      for (int j = 0; j < 2; j++) begin
        p = 0;
        // A divisor left by the random writes can hold off the first pulse a long time.
        do @(posedge sys_clk); while (bit_tick !== 1'b1 && p++ < 2000);
        p = 1;
        do begin @(posedge sys_clk); p++; end while (bit_tick !== 1'b1 && p < 100);
      end
      chk(32'(p - 1), (k == 0) ? 32'(d + 1) : 32'(4 * (d + 1)));
    end
    // Received character, its flag and the three interrupt gates.
    apb(1'b1, OFS_TX_CTL, 32'h0);
    c = 9'($urandom);
    ucs_remote_i.send(c, 2);
    rchk(OFS_PER_FLAG, 32'h20);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFS_CORE_INT, {24'h0, st[k][0]});
      apb(1'b1, OFS_PER_EN, {24'h0, st[k][1]});
      look();
      chk({31'h0, irq}, {31'h0, st[k][2][0]});
    end
    rchk(OFS_RX_CTL, {31'h0, c[8]});
    rchk(OFS_RX_DATA, {24'h0, c[7:0]});
    rchk(OFS_PER_FLAG, 32'h0);
    // Character length in bit periods, eight then nine bits.
    apb(1'b1, OFS_BAUD, 32'h3);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFS_TX_CTL, (k == 0) ? 32'h24 : 32'h64);
      rchk(OFS_PER_FLAG, 32'h10);
      apb(1'b1, OFS_RX_DATA, $urandom);
      ticks = 0;
      rchk(OFS_TX_CTL, (k == 0) ? 32'h24 : 32'h64);
      d = 0;
      do apb(1'b0, OFS_TX_CTL, 32'h0); while (rdata[1] !== 1'b1 && d++ < 100);
      chk({31'h0, ticks >= 9 + k && ticks <= 11 + k}, 32'h1);
    end
    rst_check();
    summarize();
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
endmodule : uart_control_status_bank_bench
`default_nettype wire
